// ---- verilog/mdsr_cfg.svh ----
`ifndef MDSR_CFG_SVH
`define MDSR_CFG_SVH
`define MDSR_A_ICSTAT 6'h00
`define MDSR_A_SR1 6'h01
`define MDSR_A_SR2 6'h02
`define MDSR_A_SLOT1 6'h03
`define MDSR_A_SLOT2 6'h04
`define MDSR_A_SLOT3 6'h05
`define MDSR_A_SLOT4 6'h06
`define MDSR_A_SLOT5 6'h07
`define MDSR_A_SLOT6 6'h08
`define MDSR_A_SLOT10 6'h0C
`define MDSR_R_SR2 8'h00
`define MDSR_R_SLOT1 8'h00
`define MDSR_R_SLOT2 8'h60
`define MDSR_R_SLOT3 8'h46
`define MDSR_R_SLOT4 8'h10
`define MDSR_R_SLOT5 8'h00
`define MDSR_R_SLOT6 8'h00
`define MDSR_R_SLOT10 8'h00
`define MDSR_M_SLOT1 8'h07
`define MDSR_M_SLOT2 8'hFE
`define MDSR_M_SLOT3 8'h7F
`define MDSR_M_FULL 8'hFF
`define MDSR_SR2_OTP 6
`define MDSR_SR2_SOC 5
`define MDSR_SR2_SUV 4
`define MDSR_SR2_PUV 3
`define MDSR_SR2_PAR 2
`define MDSR_SR2_FRM 1
`define MDSR_SR2_ADR 0
`define MDSR_CLR_BIT 0
`define MDSR_ODM_BIT 5
`define MDSR_LOCK_ON 3'h6
`define MDSR_LOCK_OFF 3'h3
`define MDSR_RW_BIT 15
`define MDSR_AD_HI 14
`define MDSR_AD_LO 9
`define MDSR_FRAME_BITS 5'h10
`define MDSR_STAT_BITS 5'h08
`define MDSR_ADDR_EDGE 5'h06
`endif

// ---- verilog/mdsr_pkg.sv ----
`include "mdsr_cfg.svh"
package mdsr_pkg;
    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_FRAME = 3'b010, ST_COMMIT = 3'b100} mdsr_phase_t;

    typedef struct packed {
        logic link_rst;
        logic sel_meta;
        logic sel_sync;
        logic done_meta;
        logic done_sync;
        logic done_seen;
        logic [12:0] flt_meta;
        logic [12:0] flt_sync;
        mdsr_phase_t phase;
        logic locked;
        logic [6:0][7:0] slot;
        logic par_err;
        logic frm_err;
        logic adr_err;
        logic npor;
        logic clr_pulse;
        logic [15:0][7:0] bank;
        logic [7:0] stat;
    } mdsr_state_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic [15:0] shift;
        logic [5:0] addr;
    } mdsr_live_t;

    typedef struct packed {
        logic [15:0] word;
        logic done_tog;
        logic over;
    } mdsr_hold_t;

    typedef struct packed {
        logic bit_v;
        logic oe_n;
    } mdsr_drive_t;

    function automatic logic mdsr_is_user(input logic [5:0] a);
        return (a <= `MDSR_A_SLOT6) || (a == `MDSR_A_SLOT10);
    endfunction : mdsr_is_user
endpackage : mdsr_pkg

// ---- verilog/mdsr_link_if.sv ----
`timescale 1ns/1ps
interface mdsr_link_if;
    logic [15:0][7:0] bank;
    logic [7:0] stat;
    logic od_mode;
    logic link_rst;
    logic [15:0] word;
    logic done_tog;
    logic over;
    logic sdo;
    logic sdo_oe_n;
    modport core (output bank, stat, od_mode, link_rst, input word, done_tog, over, sdo, sdo_oe_n);
    modport shifter (input bank, stat, od_mode, link_rst, output word, done_tog, over, sdo, sdo_oe_n);
endinterface : mdsr_link_if

// ---- verilog/mdsr_serial.sv ----
`timescale 1ns/1ps
`include "mdsr_cfg.svh"
module mdsr_serial (
    // serial pins
    input wire logic sclk_in,
    input wire logic sel_n_in,
    input wire logic sdi_in,
    // core side
    mdsr_link_if.shifter lk
);
    mdsr_pkg::mdsr_live_t live_r, live_nxt;
    mdsr_pkg::mdsr_hold_t hold_r, hold_nxt;
    mdsr_pkg::mdsr_drive_t drv_r, drv_nxt;
    logic [7:0] reply_byte;

    // capture on falling edge, msb first; count saturates one past a word
    always_comb
    begin
        live_nxt = live_r;
        hold_nxt = hold_r;
        live_nxt.shift = {live_r.shift[14:0], sdi_in};
        if (live_r.cnt <= `MDSR_FRAME_BITS)
        begin
            live_nxt.cnt = live_r.cnt + 5'h01;
        end
        if (live_r.cnt == `MDSR_ADDR_EDGE)
        begin
            live_nxt.addr = {live_r.shift[4:0], sdi_in};
        end
        if (live_r.cnt == `MDSR_FRAME_BITS - 5'h01)
        begin
            hold_nxt.word = live_nxt.shift;
            hold_nxt.done_tog = ~hold_r.done_tog;
            hold_nxt.over = 1'b0;
        end
        else if (live_r.cnt == `MDSR_FRAME_BITS)
        begin
            hold_nxt.over = 1'b1;
        end
    end

    // launch on rising edge: status byte, then the addressed register
    always_comb
    begin
        reply_byte = lk.bank[live_r.addr[3:0]];
        if (live_r.addr[5:4] != 2'h0)
        begin
            reply_byte = 8'h00;
        end
        drv_nxt.bit_v = 1'b0;
        if (live_r.cnt < `MDSR_STAT_BITS)
        begin
            drv_nxt.bit_v = lk.stat[3'h7 - live_r.cnt[2:0]];
        end
        else if (live_r.cnt < `MDSR_FRAME_BITS)
        begin
            drv_nxt.bit_v = reply_byte[3'h7 - live_r.cnt[2:0]];
        end
        drv_nxt.oe_n = lk.od_mode & drv_nxt.bit_v;
    end

    always_ff @(negedge sclk_in or posedge sel_n_in)
    begin
        if (sel_n_in)
            live_r <= '0;
        else
            live_r <= live_nxt;
    end

    always_ff @(negedge sclk_in or posedge lk.link_rst)
    begin
        if (lk.link_rst)
            hold_r <= '0;
        else
            hold_r <= hold_nxt;
    end

    always_ff @(posedge sclk_in or posedge sel_n_in)
    begin
        if (sel_n_in)
            drv_r <= '{bit_v: 1'b0, oe_n: 1'b1};
        else
            drv_r <= drv_nxt;
    end

    assign lk.word = hold_r.word;
    assign lk.done_tog = hold_r.done_tog;
    assign lk.over = hold_r.over;
    assign lk.sdo = drv_r.bit_v;
    assign lk.sdo_oe_n = drv_r.oe_n;
endmodule : mdsr_serial

// ---- verilog/mdsr_regs.sv ----
`timescale 1ns/1ps
`include "mdsr_cfg.svh"

// What this block does
// - status one bit 7 reads 1 while thermal warning is detected
// - status one bit 6 reads 1 while thermal shutdown is detected
// - status one bits 5..0 show per-switch overcurrent, phase C high first
// - status two bit 6 flags memory error; bit 7 reads zero
// - status two bit 5 follows step-down regulator overcurrent
// - status two bit 4 follows step-down regulator undervoltage
// - status two bit 3 follows charge pump undervoltage
// - status two bit 2 sets on a serial parity error
// - status two bit 1 sets on a frame not exactly sixteen clocks long
// - status two bit 0 sets on access to a non-user address
// - status two sits at offset 2 and is zero after reset
// - config slot one sits at offset 3 and is zero after reset
// - one 16-bit frame: rw, 6-bit address, parity, data; reply status then data
// - while unlocked, writing 1 to slot two bit 0 clears latched faults, then self-clears
module mdsr_regs (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // serial link
    input wire logic sclk_in,
    input wire logic sel_n_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_n_out,
    // fault detector levels
    input wire logic thermal_warning_flag_in,
    input wire logic thermal_shutdown_flag_in,
    input wire logic phase_c_high_overcurrent_in,
    input wire logic phase_c_low_overcurrent_in,
    input wire logic phase_b_high_overcurrent_in,
    input wire logic phase_b_low_overcurrent_in,
    input wire logic phase_a_high_overcurrent_in,
    input wire logic phase_a_low_overcurrent_in,
    input wire logic stepdown_overcurrent_flag_in,
    input wire logic stepdown_undervoltage_flag_in,
    input wire logic pump_undervoltage_flag_in,
    input wire logic otp_error_flag_in,
    input wire logic supply_overvoltage_flag_in,
    // configuration to the driver core
    output logic [7:0] slot_one_out,
    output logic [7:0] slot_two_out,
    output logic [7:0] slot_three_out,
    output logic [7:0] slot_four_out,
    output logic [7:0] slot_five_out,
    output logic [7:0] slot_six_out,
    output logic [7:0] slot_ten_out,
    output logic fault_clear_command_out,
    output logic regs_locked_out
);
    mdsr_link_if lk ();
    mdsr_pkg::mdsr_state_t st_r, st_nxt;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic frame_new;
    logic wr_en;
    logic par_set;
    logic frm_set;
    logic adr_set;
    logic [7:0] sr1_v;
    logic [7:0] sr2_v;
    logic [7:0] stat_v;
    logic [15:0][7:0] bank_v;

    function automatic logic [5:0] slot_addr(input int i);
        slot_addr = (i == 6) ? `MDSR_A_SLOT10 : `MDSR_A_SLOT1 + 6'(i);
    endfunction : slot_addr

    function automatic logic [7:0] slot_mask(input int i);
        case (i)
            0: slot_mask = `MDSR_M_SLOT1;
            1: slot_mask = `MDSR_M_SLOT2;
            2: slot_mask = `MDSR_M_SLOT3;
            default: slot_mask = `MDSR_M_FULL;
        endcase
    endfunction : slot_mask

    mdsr_serial u_serial (
        .sclk_in(sclk_in),
        .sel_n_in(sel_n_in),
        .sdi_in(sdi_in),
        .lk(lk.shifter)
    );

    assign waddr = lk.word[`MDSR_AD_HI:`MDSR_AD_LO];
    assign wdata = lk.word[7:0];
    // the held word only changes while a frame runs, so it is read here once the frame has ended
    assign frame_new = st_r.done_sync != st_r.done_seen;

    always_comb
    begin
        st_nxt = st_r;
        wr_en = 1'b0;
        par_set = 1'b0;
        frm_set = 1'b0;
        adr_set = 1'b0;
        // two-flop synchronisers for the select, the frame toggle and the detector levels
        st_nxt.link_rst = rst_in;
        st_nxt.sel_meta = sel_n_in;
        st_nxt.sel_sync = st_r.sel_meta;
        st_nxt.done_meta = lk.done_tog;
        st_nxt.done_sync = st_r.done_meta;
        st_nxt.flt_meta = {thermal_warning_flag_in, thermal_shutdown_flag_in,
                           phase_c_high_overcurrent_in, phase_c_low_overcurrent_in,
                           phase_b_high_overcurrent_in, phase_b_low_overcurrent_in,
                           phase_a_high_overcurrent_in, phase_a_low_overcurrent_in,
                           stepdown_overcurrent_flag_in, stepdown_undervoltage_flag_in,
                           pump_undervoltage_flag_in, otp_error_flag_in, supply_overvoltage_flag_in};
        st_nxt.flt_sync = st_r.flt_meta;
        st_nxt.clr_pulse = 1'b0;

        // frame tracking on the synchronised select
        case (st_r.phase)
            mdsr_pkg::ST_IDLE:
            begin
                if (!st_r.sel_sync)
                begin
                    st_nxt.phase = mdsr_pkg::ST_FRAME;
                end
            end
            mdsr_pkg::ST_FRAME:
            begin
                if (st_r.sel_sync)
                begin
                    st_nxt.phase = mdsr_pkg::ST_COMMIT;
                end
            end
            mdsr_pkg::ST_COMMIT:
            begin
                st_nxt.phase = mdsr_pkg::ST_IDLE;
                st_nxt.done_seen = st_r.done_sync;
                if (!frame_new || lk.over)
                begin
                    frm_set = 1'b1;
                end
                else if (^lk.word)
                begin
                    par_set = 1'b1;
                end
                else if (!mdsr_pkg::mdsr_is_user(waddr))
                begin
                    adr_set = 1'b1;
                end
                else
                begin
                    wr_en = !lk.word[`MDSR_RW_BIT];
                end
            end
            default:
            begin
                st_nxt.phase = mdsr_pkg::ST_IDLE;
            end
        endcase

        // status offsets match no slot, so such writes fall through
        for (int i = 0; i < 7; i++)
        begin
            if (wr_en && waddr == slot_addr(i) && (!st_r.locked || i == 0))
            begin
                st_nxt.slot[i] = wdata & slot_mask(i);
            end
        end
        // slot one also carries the lock codes
        if (wr_en && waddr == `MDSR_A_SLOT1)
        begin
            if (wdata[2:0] == `MDSR_LOCK_ON)
            begin
                st_nxt.locked = 1'b1;
            end
            else if (wdata[2:0] == `MDSR_LOCK_OFF)
            begin
                st_nxt.locked = 1'b0;
            end
        end
        if (wr_en && waddr == `MDSR_A_SLOT2 && !st_r.locked)
        begin
            st_nxt.clr_pulse = wdata[`MDSR_CLR_BIT];
        end

        // latched link errors: a new error wins over a clear in the same cycle
        st_nxt.par_err = (st_r.par_err & ~st_r.clr_pulse) | par_set;
        st_nxt.frm_err = (st_r.frm_err & ~st_r.clr_pulse) | frm_set;
        st_nxt.adr_err = (st_r.adr_err & ~st_r.clr_pulse) | adr_set;
        st_nxt.npor = st_r.npor | st_r.clr_pulse;

        sr1_v = st_r.flt_sync[12:5];
        sr2_v = '0;
        sr2_v[`MDSR_SR2_OTP] = st_r.flt_sync[1];
        sr2_v[`MDSR_SR2_SOC] = st_r.flt_sync[4];
        sr2_v[`MDSR_SR2_SUV] = st_r.flt_sync[3];
        sr2_v[`MDSR_SR2_PUV] = st_r.flt_sync[2];
        sr2_v[`MDSR_SR2_PAR] = st_r.par_err;
        sr2_v[`MDSR_SR2_FRM] = st_r.frm_err;
        sr2_v[`MDSR_SR2_ADR] = st_r.adr_err;
        // summary byte: buck, link, overcurrent, no-por, overvoltage, thermal, any
        stat_v = {1'b0, st_r.flt_sync[4] | st_r.flt_sync[3],
                  st_r.par_err | st_r.frm_err | st_r.adr_err,
                  |st_r.flt_sync[10:5], st_r.npor, st_r.flt_sync[0],
                  st_r.flt_sync[12] | st_r.flt_sync[11],
                  |{sr1_v, sr2_v, st_r.flt_sync[0]}};
        bank_v = '0;
        bank_v[`MDSR_A_ICSTAT] = stat_v;
        bank_v[`MDSR_A_SR1] = sr1_v;
        bank_v[`MDSR_A_SR2] = sr2_v;
        for (int i = 0; i < 7; i++)
        begin
            bank_v[slot_addr(i)] = st_r.slot[i];
        end
        // the shadow the shifter reads is frozen while a frame runs
        if (st_r.phase == mdsr_pkg::ST_IDLE)
        begin
            st_nxt.bank = bank_v;
            st_nxt.stat = stat_v;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            st_r <= '0;
            st_r.phase <= mdsr_pkg::ST_IDLE;
            st_r.sel_meta <= 1'b1;
            st_r.sel_sync <= 1'b1;
            st_r.link_rst <= 1'b1;
            st_r.slot <= {`MDSR_R_SLOT10, `MDSR_R_SLOT6, `MDSR_R_SLOT5, `MDSR_R_SLOT4,
                          `MDSR_R_SLOT3, `MDSR_R_SLOT2, `MDSR_R_SLOT1};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign lk.bank = st_r.bank;
    assign lk.stat = st_r.stat;
    assign lk.od_mode = ~st_r.slot[1][`MDSR_ODM_BIT];
    assign lk.link_rst = st_r.link_rst;
    assign sdo_out = lk.sdo;
    assign sdo_oe_n_out = lk.sdo_oe_n;
    assign slot_one_out = st_r.slot[0];
    assign slot_two_out = st_r.slot[1];
    assign slot_three_out = st_r.slot[2];
    assign slot_four_out = st_r.slot[3];
    assign slot_five_out = st_r.slot[4];
    assign slot_six_out = st_r.slot[5];
    assign slot_ten_out = st_r.slot[6];
    assign fault_clear_command_out = st_r.clr_pulse;
    assign regs_locked_out = st_r.locked;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    AST_WARN_SHOWN:
    assert property (st_r.phase == mdsr_pkg::ST_IDLE |=> st_r.bank[`MDSR_A_SR1][7] == $past(st_r.flt_sync[12]))
        else $error("thermal warning not shown in status one");
    AST_SHUTDOWN_SHOWN:
    assert property ($rose(st_r.flt_sync[11]) && st_r.phase == mdsr_pkg::ST_IDLE |=> st_r.bank[`MDSR_A_SR1][6])
        else $error("thermal shutdown not shown in status one");
    AST_OCP_ORDER:
    assert property ((st_r.phase == mdsr_pkg::ST_IDLE) [*2] |-> st_r.bank[`MDSR_A_SR1][5:0] == $past(st_r.flt_sync[10:5]))
        else $error("switch overcurrent bits out of order");
    AST_OTP_SHOWN:
    assert property (st_r.phase == mdsr_pkg::ST_IDLE |=> !st_r.bank[`MDSR_A_SR2][7] &&
                     st_r.bank[`MDSR_A_SR2][`MDSR_SR2_OTP] == $past(st_r.flt_sync[1]))
        else $error("memory error bit wrong or bit 7 set");
    AST_SOC_CLEAR:
    assert property (st_r.phase == mdsr_pkg::ST_IDLE && !st_r.flt_sync[4] |=> !st_r.bank[`MDSR_A_SR2][`MDSR_SR2_SOC])
        else $error("regulator overcurrent bit stuck");
    AST_SUV_SET:
    assert property (st_r.phase == mdsr_pkg::ST_IDLE && st_r.flt_sync[3] |=> st_r.bank[`MDSR_A_SR2][`MDSR_SR2_SUV])
        else $error("regulator undervoltage bit missing");
    AST_PUV_SHOWN:
    assert property (st_r.phase == mdsr_pkg::ST_IDLE |=> st_r.bank[`MDSR_A_SR2][`MDSR_SR2_PUV] == $past(st_r.flt_sync[2]))
        else $error("pump undervoltage bit wrong");
    AST_PARITY_FLAG:
    assert property (st_r.phase == mdsr_pkg::ST_COMMIT && frame_new && !lk.over && ^lk.word |=> st_r.par_err ##1
                     st_r.phase != mdsr_pkg::ST_IDLE || st_r.bank[`MDSR_A_SR2][`MDSR_SR2_PAR])
        else $error("parity error not flagged");
    AST_FRAME_SHORT:
    assert property (st_r.phase == mdsr_pkg::ST_COMMIT && !frame_new |=> st_r.frm_err && $stable(st_r.slot))
        else $error("short frame not flagged");
    AST_BAD_ADDR:
    assert property (st_r.phase == mdsr_pkg::ST_COMMIT && frame_new && !lk.over && !(^lk.word) &&
                     !mdsr_pkg::mdsr_is_user(waddr) |=> st_r.adr_err)
        else $error("non-user address not flagged");
    AST_SR2_RESET:
    assert property ($past(rst_in) |-> st_r.bank[`MDSR_A_SR2] == `MDSR_R_SR2)
        else $error("status two not zero after reset");
    AST_SLOT1_RESET:
    assert property ($past(rst_in) |-> st_r.slot[0] == `MDSR_R_SLOT1 && !st_r.locked)
        else $error("slot one not zero after reset");
    AST_FRAME_LONG:
    assert property (st_r.phase == mdsr_pkg::ST_COMMIT && lk.over |=> st_r.frm_err && !st_r.clr_pulse)
        else $error("long frame accepted");
    AST_CLEAR_SELF:
    assert property (st_r.clr_pulse |=> !st_r.clr_pulse && !st_r.par_err && !st_r.frm_err && !st_r.adr_err &&
                     !st_r.slot[1][`MDSR_CLR_BIT])
        else $error("fault clear did not clear or self-reset");
    AST_STATUS_RO:
    assert property (wr_en && waddr <= `MDSR_A_SR2 |=> $stable(st_r.slot) && !st_r.clr_pulse)
        else $error("write to status register had an effect");

    // link error flags stay latched until a fault clear
    AST_PARITY_KEPT:
    assert property (st_r.par_err && !st_r.clr_pulse |=> st_r.par_err)
        else $error("parity error flag lost");
    AST_FRAMING_KEPT:
    assert property (st_r.frm_err && !st_r.clr_pulse |=> st_r.frm_err)
        else $error("framing error flag lost");
    AST_ADDR_KEPT:
    assert property (st_r.adr_err && !st_r.clr_pulse |=> st_r.adr_err)
        else $error("address error flag lost");
    AST_CLEAR_STROBE:
    assert property (wr_en && waddr == `MDSR_A_SLOT2 && wdata[`MDSR_CLR_BIT] && !st_r.locked |=> st_r.clr_pulse)
        else $error("fault clear write gave no strobe");
    AST_READ_NO_EFFECT:
    assert property (st_r.phase == mdsr_pkg::ST_COMMIT && frame_new && lk.word[`MDSR_RW_BIT] |=>
                     $stable(st_r.slot) && $stable(st_r.locked) && !st_r.clr_pulse)
        else $error("read changed register contents");
    AST_SLOT3_WRITE:
    assert property (st_r.phase == mdsr_pkg::ST_COMMIT && frame_new && !lk.over && !(^lk.word) &&
                     !lk.word[`MDSR_RW_BIT] && waddr == `MDSR_A_SLOT3 && !st_r.locked |=>
                     st_r.slot[2] == ($past(wdata) & `MDSR_M_SLOT3))
        else $error("valid write to slot three not applied");
    AST_SHADOW_FROZEN:
    assert property (st_r.phase != mdsr_pkg::ST_IDLE |=> $stable(st_r.bank) && $stable(st_r.stat))
        else $error("reply shadow changed during a frame");
    AST_LOCK_HOLDS:
    assert property (st_r.locked && wr_en && waddr != `MDSR_A_SLOT1 |=> $stable(st_r.slot) && !st_r.clr_pulse)
        else $error("write accepted while locked");

    COV_WRITE: cover property (wr_en && waddr == `MDSR_A_SLOT3);
    COV_CLEAR: cover property (st_r.par_err ##[1:1000] st_r.clr_pulse);
    COV_LONG_FRAME: cover property (st_r.phase == mdsr_pkg::ST_COMMIT && lk.over);
    COV_FRAME_ERR: cover property (frm_set);
    COV_LOCKED_WRITE: cover property (st_r.locked && wr_en && waddr == `MDSR_A_SLOT4);
endmodule : mdsr_regs

// ---- sim/mdsr_master.sv ----
`timescale 1ns/1ps
module mdsr_master (
    // serial pins
    output logic sclk_out,
    output logic sel_n_out,
    output logic sdi_out,
    // reply line as seen on the board
    input wire logic sdo_in
);
    initial
    begin
        sclk_out = 1'b0;
        sel_n_out = 1'b1;
        sdi_out = 1'b0;
    end

    // one frame, msb first; sclk idles low and stands still between frames
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] reply);
        reply = 16'h0000;
        #1.7;
        sel_n_out = 1'b0;
        #20;
        for (int k = 0; k < nbits; k++)
        begin
            sclk_out = 1'b1;
            sdi_out = (k < 16) ? word[15 - k] : 1'b0;
            #7.5;
            sclk_out = 1'b0;
            reply = {reply[14:0], sdo_in};
            #7.5;
        end
        #10;
        sel_n_out = 1'b1;
        // released data line must not keep its last level
        sdi_out = ~sdi_out;
        // select stays high well beyond the 400 ns gap
        #450;
    endtask : xfer
endmodule : mdsr_master

// ---- sim/mdsr_regs_tb_top.sv ----
`timescale 1ns/1ps
`include "mdsr_cfg.svh"
module mdsr_regs_tb_top;
    logic mclk_in;
    logic rst_in;
    logic sclk;
    logic sel_n;
    logic sdi;
    logic sdo;
    logic sdo_oe_n;
    logic sdo_line;
    logic [12:0] flt;
    logic [6:0][7:0] slots;
    logic clr_pulse;
    logic locked;
    logic [15:0] rep;
    int mismatches;
    int compares;
    int clr_cnt;
    int n;
    logic [5:0] s_adr [7] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0C};
    logic [7:0] s_msk [7] = '{8'h07, 8'hFE, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] s_rst [7] = '{8'h00, 8'h60, 8'h46, 8'h10, 8'h00, 8'h00, 8'h00};

    // pull-up holds the line high whenever the device lets go of it
    assign sdo_line = (sdo_oe_n === 1'b0) ? sdo : 1'b1;

    mdsr_regs i_mdsr_regs (
        .mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(sclk), .sel_n_in(sel_n), .sdi_in(sdi),
        .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n),
        .thermal_warning_flag_in(flt[7]), .thermal_shutdown_flag_in(flt[6]),
        .phase_c_high_overcurrent_in(flt[5]), .phase_c_low_overcurrent_in(flt[4]),
        .phase_b_high_overcurrent_in(flt[3]), .phase_b_low_overcurrent_in(flt[2]),
        .phase_a_high_overcurrent_in(flt[1]), .phase_a_low_overcurrent_in(flt[0]),
        .pump_undervoltage_flag_in(flt[8]), .stepdown_undervoltage_flag_in(flt[9]),
        .stepdown_overcurrent_flag_in(flt[10]), .otp_error_flag_in(flt[11]),
        .supply_overvoltage_flag_in(flt[12]),
        .slot_one_out(slots[0]), .slot_two_out(slots[1]), .slot_three_out(slots[2]),
        .slot_four_out(slots[3]), .slot_five_out(slots[4]), .slot_six_out(slots[5]),
        .slot_ten_out(slots[6]), .fault_clear_command_out(clr_pulse), .regs_locked_out(locked)
    );

    mdsr_master i_mdsr_master (.sclk_out(sclk), .sel_n_out(sel_n), .sdi_out(sdi), .sdo_in(sdo_line));

    initial
    begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end

    // counts mclk cycles in which the clear strobe is high
    always @(posedge mclk_in)
    begin
        if (clr_pulse === 1'b1)
            clr_cnt <= clr_cnt + 1;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic acc(input logic rw, input logic [5:0] a, input logic [7:0] d, input logic bad, input int nb);
        logic p;
        p = (^{rw, a, d}) ^ bad;
        @(posedge mclk_in);
        i_mdsr_master.xfer({rw, a, p, d}, nb, rep);
    endtask : acc

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        acc(1'b1, a, 8'h00, 1'b0, 16);
        chk($sformatf("read of %h", a), rep[7:0], exp);
    endtask : rd

    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    initial
    begin
        #200000;
        mismatches++;
        summarize();
    end

    initial
    begin
        rst_in = 1'b1;
        flt = 13'h0000;
        mismatches = 0;
        compares = 0;
        clr_cnt = 0;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        for (int i = 0; i < 7; i++)
            chk("slot output after reset", slots[i], s_rst[i]);
        rd(`MDSR_A_SR2, 8'h00);
        rd(`MDSR_A_SLOT1, 8'h00);
        // one detector at a time, each read twice
        for (int i = 0; i < 12; i++)
        begin
            @(posedge mclk_in);
            flt <= 13'h0001 << i;
            repeat (6) @(posedge mclk_in);
            rd((i < 8) ? `MDSR_A_SR1 : `MDSR_A_SR2, (i < 8) ? 8'h01 << i : 8'h08 << (i - 8));
            rd((i < 8) ? `MDSR_A_SR1 : `MDSR_A_SR2, (i < 8) ? 8'h01 << i : 8'h08 << (i - 8));
        end
        @(posedge mclk_in);
        flt <= 13'h1FFF;
        repeat (6) @(posedge mclk_in);
        rd(`MDSR_A_SR1, 8'hFF);
        rd(`MDSR_A_SR2, 8'h78);
        chk("status byte", rep[15:8], 8'h57);
        chk("reply enable between frames", {7'h00, sdo_oe_n}, 8'h01);
        @(posedge mclk_in);
        flt <= 13'h0000;
        repeat (6) @(posedge mclk_in);
        rd(`MDSR_A_SR1, 8'h00);
        rd(`MDSR_A_SR2, 8'h00);
        acc(1'b0, `MDSR_A_SR2, 8'hFF, 1'b0, 16);
        rd(`MDSR_A_SR2, 8'h00);
        // writes go only to listed control offsets
        for (int i = 0; i < 7; i++)
        begin
            acc(1'b0, s_adr[i], 8'h14, 1'b0, 16);
            chk("old contents", rep[7:0], s_rst[i]);
            chk("slot output", slots[i], 8'h14 & s_msk[i]);
            rd(s_adr[i], 8'h14 & s_msk[i]);
        end
        // lock, try a write elsewhere, then unlock
        acc(1'b0, `MDSR_A_SLOT1, 8'h06, 1'b0, 16);
        chk("lock state", {7'h00, locked}, 8'h01);
        acc(1'b0, `MDSR_A_SLOT4, 8'h5A, 1'b0, 16);
        rd(`MDSR_A_SLOT4, 8'h14);
        acc(1'b0, `MDSR_A_SLOT1, 8'h03, 1'b0, 16);
        chk("lock state", {7'h00, locked}, 8'h00);
        rd(`MDSR_A_SLOT1, 8'h03);
        // address fault, short frame, parity fault, long frame; each latched, then cleared
        for (int e = 0; e < 4; e++)
        begin
            acc(1'b1, (e == 0) ? 6'h0A : `MDSR_A_SR1, 8'h00, e == 2, (e == 1) ? 15 : ((e == 3) ? 17 : 16));
            rd(`MDSR_A_SR2, 8'h01 << ((e == 3) ? 1 : e));
            rd(`MDSR_A_SR2, 8'h01 << ((e == 3) ? 1 : e));
            n = clr_cnt;
            acc(1'b0, `MDSR_A_SLOT2, 8'h15, 1'b0, 16);
            chk("clear strobe cycles", 8'(clr_cnt - n), 8'h01);
            rd(`MDSR_A_SR2, 8'h00);
        end
        rd(`MDSR_A_SLOT2, 8'h14);
        // latch an error, then reset again in mid-run
        acc(1'b1, 6'h0A, 8'h00, 1'b0, 16);
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        for (int i = 0; i < 7; i++)
            chk("slot output after second reset", slots[i], s_rst[i]);
        chk("lock after second reset", {7'h00, locked}, 8'h00);
        rd(`MDSR_A_SR2, 8'h00);
        summarize();
    end
endmodule : mdsr_regs_tb_top
